// ---- rtl/scl_pkg.sv ----
// constants for the sequencer condition mux and addressable latch
package scl_pkg;
	// ==========================================================
	// clock and sequencer step timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int STEP_NS = 50;
	localparam int HOST_STATE_NS = 100;
	localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_CNT_W = 4;

	// ==========================================================
	// host register port
	localparam int ADDR_W = 2;
	localparam logic [ADDR_W-1:0] OFS_CMD = 2'h0;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 2'h1;
	localparam logic [ADDR_W-1:0] OFS_SCSI = 2'h2;
	localparam logic [ADDR_W-1:0] OFS_TAPE = 2'h3;

	// command register layout
	localparam int CMD_W = 6;
	localparam int CMD_VALID_BIT = 6;
	localparam int CMD_PARITY_BIT = 7;

	// status register layout
	localparam int ST_DMSG_BIT = 0;
	localparam int ST_VALID_BIT = 1;
	localparam int ST_SCSI_PEND_BIT = 2;
	localparam int ST_TAPE_PEND_BIT = 3;
	localparam int ST_INT_BIT = 4;
	localparam int ST_TRDY_BIT = 5;
	localparam int ST_EXC_BIT = 6;
	localparam int ST_PARITY_BIT = 7;

	// ==========================================================
	// condition select codes
	localparam logic [3:0] SEL_VALID = 4'h0;
	localparam logic [3:0] SEL_DDACK = 4'h1;
	localparam logic [3:0] SEL_DREQ = 4'h2;
	localparam logic [3:0] SEL_TACK = 4'h3;
	localparam logic [3:0] SEL_XACK_REQ = 4'h4;
	localparam logic [3:0] SEL_XACK_NREQ = 4'h5;
	localparam logic [3:0] SEL_MSG_TRDY = 4'h6;
	localparam logic [3:0] SEL_EXC = 4'h7;
	localparam logic [3:0] SEL_BUSY = 4'h8;
	localparam logic [3:0] SEL_ONE = 4'h9;
	localparam logic [3:0] SEL_XACK = 4'hA;
	localparam logic [3:0] SEL_DREQ_DDACK = 4'hB;
	localparam logic [3:0] SEL_TRDY = 4'hC;

	// ==========================================================
	// addressable latch bit positions
	localparam int LB_ATTN = 0;
	localparam int LB_SRST = 1;
	localparam int LB_HINT = 2;
	localparam int LB_XREQ = 3;
	localparam int LB_TONL = 4;
	localparam int LB_TRIE = 5;
	localparam int LB_TRST = 6;
	localparam int LB_SACK = 7;
	localparam logic [7:0] LATCH_RST = 8'h00;
endpackage

// ---- rtl/scl_top.sv ----
// condition select mux, addressable latch unit and host command register
// ==========================================================
module scl_top
	import scl_pkg::*;
(
	input wire logic i_clk, // 100 MHz clock
	input wire logic i_resetn, // async reset, active low
	// sequencer side
	input wire logic [8:3] i_seq_lines, // sequencer output lines P3..P8
	input wire logic i_ready_req, // sequencer ready request
	input wire logic i_cmd_ack, // sequencer clears valid flag
	input wire logic i_scsi_done, // sequencer finished disk select
	input wire logic i_tape_done, // sequencer finished tape command
	output logic o_condition_input, // registered condition to sequencer
	output logic [5:0] o_branch_address_inputs, // command to branch inputs
	output logic o_step, // one-cycle sequencer step enable
	// host register port
	input wire logic [scl_pkg::ADDR_W-1:0] i_addr, // register address
	input wire logic [7:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [7:0] o_rdata, // read data, cycle after read strobe
	output logic o_ready, // host bus ready
	output logic o_host_interrupt_line, // interrupt to host
	output logic o_xfer_req, // host transfer request
	output logic [7:0] o_port_data, // byte last written to a port
	output logic o_scsi_pend, // disk select byte waiting
	output logic o_tape_pend, // tape command byte waiting
	// pins from outside (synchronised)
	input wire logic i_ddack, // disk dma acknowledge
	input wire logic i_dreq, // disk request
	input wire logic i_tack, // tape acknowledge
	input wire logic i_xack, // host transfer acknowledge
	input wire logic i_exc, // tape exception
	input wire logic i_busy, // disk busy sense
	input wire logic i_msg, // disk message line
	input wire logic i_cd, // disk command/data line
	input wire logic i_trdy, // tape ready
	input wire logic i_parity_err, // transceiver parity error
	// pins to outside
	output logic o_dmsg, // disk message flag
	output logic o_scsi_attn, // disk attention
	output logic o_scsi_rst, // disk reset
	output logic o_scsi_ack, // disk acknowledge
	output logic o_tape_online, // tape online
	output logic o_tape_rst // tape reset
);
	import scl_pkg::*;

	// ==========================================================
	// pin synchronisers
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic ddack_s;
	logic dreq_s;
	logic tack_s;
	logic xack_s;
	logic exc_s;
	logic busy_s;
	logic msg_s;
	logic cd_s;
	logic trdy_s;
	logic parity_s;

	assign pin_raw = {i_parity_err, i_trdy, i_cd, i_msg, i_busy,
		i_exc, i_xack, i_tack, i_dreq, i_ddack};

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
		end
	end

	assign {parity_s, trdy_s, cd_s, msg_s, busy_s,
		exc_s, xack_s, tack_s, dreq_s, ddack_s} = sync2_r;

	// ==========================================================
	// sequencer step divider
	logic [STEP_CNT_W-1:0] step_cnt_r;

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			step_cnt_r <= '0;
			o_step <= 1'b0;
		end
		else if (step_cnt_r == STEP_CNT_W'(STEP_CYC - 1))
		begin
			step_cnt_r <= '0;
			o_step <= 1'b1;
		end
		else
		begin
			step_cnt_r <= step_cnt_r + 1'b1;
			o_step <= 1'b0;
		end
	end

	// ==========================================================
	// addressable latch unit
	logic [7:0] latch_r;
	logic latch_rstn;
	logic [2:0] latch_addr;

	assign latch_addr = i_seq_lines[6:4];

	// P3 clears asynchronously
	// gated reset: P3 must come glitch-free from the sequencer register
	assign latch_rstn = i_resetn & ~i_seq_lines[3];

	always_ff @(posedge i_clk or negedge latch_rstn)
	begin
		if (!latch_rstn)
			latch_r <= LATCH_RST;
		else if (o_step && i_seq_lines[8])
			latch_r[latch_addr] <= i_seq_lines[7];
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_scsi_attn <= 1'b0;
			o_scsi_rst <= 1'b0;
			o_host_interrupt_line <= 1'b0;
			o_xfer_req <= 1'b0;
			o_tape_online <= 1'b0;
			o_tape_rst <= 1'b0;
			o_scsi_ack <= 1'b0;
		end
		else
		begin
			o_scsi_attn <= latch_r[LB_ATTN];
			o_scsi_rst <= latch_r[LB_SRST];
			o_host_interrupt_line <= latch_r[LB_HINT];
			o_xfer_req <= latch_r[LB_XREQ];
			o_tape_online <= latch_r[LB_TONL];
			o_tape_rst <= latch_r[LB_TRST];
			o_scsi_ack <= latch_r[LB_SACK];
		end
	end

	// ==========================================================
	// condition select mux
	logic [3:0] cond_sel;
	logic valid_r;
	logic cond_nxt;

	assign cond_sel = i_seq_lines[6:3];

	always_comb
	begin
		unique case (cond_sel)
			SEL_VALID: cond_nxt = valid_r;
			SEL_DDACK: cond_nxt = ddack_s;
			SEL_DREQ: cond_nxt = dreq_s;
			SEL_TACK: cond_nxt = tack_s;
			SEL_XACK_REQ: cond_nxt = xack_s & latch_r[LB_XREQ];
			SEL_XACK_NREQ: cond_nxt = xack_s & ~latch_r[LB_XREQ];
			SEL_MSG_TRDY: cond_nxt = (msg_s & cd_s)
				| (latch_r[LB_TRIE] & trdy_s);
			SEL_EXC: cond_nxt = exc_s;
			SEL_BUSY: cond_nxt = busy_s;
			SEL_ONE: cond_nxt = 1'b1;
			SEL_XACK: cond_nxt = xack_s;
			SEL_DREQ_DDACK: cond_nxt = dreq_s & ddack_s;
			SEL_TRDY: cond_nxt = trdy_s;
			default: cond_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_condition_input <= 1'b0;
		else
			o_condition_input <= cond_nxt;
	end

	// ==========================================================
	// ready and disk message
	// registered here: adds one cycle of lag, well inside a 100 ns state
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_ready <= 1'b1;
			o_dmsg <= 1'b0;
		end
		else
		begin
			o_ready <= i_ready_req | (~ddack_s & ~i_ready_req);
			o_dmsg <= msg_s & cd_s;
		end
	end

	// ==========================================================
	// host command register and port intercepts
	logic parity_r;
	logic host_cmd_wr;
	logic scsi_wr;
	logic tape_wr;

	assign host_cmd_wr = i_wr && (i_addr == OFS_CMD);
	assign scsi_wr = i_wr && (i_addr == OFS_SCSI);
	assign tape_wr = i_wr && (i_addr == OFS_TAPE);

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_branch_address_inputs <= '0;
			valid_r <= 1'b0;
		end
		else
		begin
			if (host_cmd_wr)
				o_branch_address_inputs <= i_wdata[CMD_W-1:0];
			// ack clears; a new command wins
			if (host_cmd_wr)
				valid_r <= 1'b1;
			else if (i_cmd_ack)
				valid_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			parity_r <= 1'b0;
		else if (parity_s)
			parity_r <= 1'b1;
		else if (host_cmd_wr && !i_wdata[CMD_PARITY_BIT])
			parity_r <= 1'b0;
	end

	// hold port bytes for the sequencer
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_port_data <= 8'h00;
			o_scsi_pend <= 1'b0;
			o_tape_pend <= 1'b0;
		end
		else
		begin
			if (scsi_wr || tape_wr)
				o_port_data <= i_wdata;
			if (scsi_wr)
				o_scsi_pend <= 1'b1;
			else if (i_scsi_done)
				o_scsi_pend <= 1'b0;
			if (tape_wr)
				o_tape_pend <= 1'b1;
			else if (i_tape_done)
				o_tape_pend <= 1'b0;
		end
	end

	// ==========================================================
	// read port
	logic [7:0] status_val;

	always_comb
	begin
		status_val = 8'h00;
		status_val[ST_DMSG_BIT] = o_dmsg;
		status_val[ST_VALID_BIT] = valid_r;
		status_val[ST_SCSI_PEND_BIT] = o_scsi_pend;
		status_val[ST_TAPE_PEND_BIT] = o_tape_pend;
		status_val[ST_INT_BIT] = latch_r[LB_HINT];
		status_val[ST_TRDY_BIT] = trdy_s;
		status_val[ST_EXC_BIT] = exc_s;
		status_val[ST_PARITY_BIT] = parity_r;
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_rdata <= 8'h00;
		else if (i_rd)
		begin
			unique case (i_addr)
				OFS_CMD: o_rdata <= {parity_r, valid_r,
					o_branch_address_inputs};
				OFS_STATUS: o_rdata <= status_val;
				OFS_SCSI, OFS_TAPE: o_rdata <= o_port_data;
			endcase
		end
		else
			o_rdata <= 8'h00;
	end
endmodule // scl_top

// ---- test/scl_props.sv ----
// assertions on the condition mux, ready, flag and latch ports
module scl_props
(
	input wire logic i_clk, // clock
	input wire logic i_resetn, // reset, active low
	input wire logic [8:3] i_seq_lines, // P3..P8
	input wire logic i_ready_req, // ready request
	input wire logic i_ddack, // dma ack
	input wire logic i_dreq, // disk request
	input wire logic i_msg, // message line
	input wire logic i_cd, // command/data line
	input wire logic o_condition_input, // condition
	input wire logic o_ready, // host ready
	input wire logic o_dmsg, // message flag
	input wire logic o_step, // step pulse
	input wire logic o_host_interrupt_line, // latch bit 2
	input wire logic o_xfer_req, // latch bit 3
	input wire logic o_scsi_attn, // latch bit 0
	input wire logic o_scsi_rst, // latch bit 1
	input wire logic o_scsi_ack, // latch bit 7
	input wire logic o_tape_online, // latch bit 4
	input wire logic o_tape_rst // latch bit 6
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] pins;
	logic wr_ok;
	// bit 5 has no pin of its own, so it reads as zero here
	assign pins = {o_scsi_ack, o_tape_rst, 1'b0, o_tape_online, o_xfer_req,
		o_host_interrupt_line, o_scsi_rst, o_scsi_attn};
	assign wr_ok = o_step && i_seq_lines[8] && !i_seq_lines[3]
		&& i_seq_lines[6:4] != 3'h5;
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	// ==========================================================
	// condition mux, ready and message flag
	property p_unused;
		i_seq_lines[6:3] > 4'hC |=> !o_condition_input;
	endproperty
	a_unused: assert property (p_unused)
		else $error("unused select drove condition high");
	property p_and_b;
		i_seq_lines[6:3] == 4'hB |=>
			o_condition_input == ($past(i_dreq, 3) && $past(i_ddack, 3));
	endproperty
	a_and_b: assert property (p_and_b)
		else $error("select 11 condition wrong");
	property p_ready;
		1'b1 |=> o_ready == ($past(i_ready_req) || !$past(i_ddack, 3));
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready output wrong");
	property p_dmsg;
		1'b1 |=> o_dmsg == ($past(i_msg, 3) && $past(i_cd, 3));
	endproperty
	a_dmsg: assert property (p_dmsg)
		else $error("message flag wrong");
	// ==========================================================
	// addressable latch and step
	property p_clear;
		i_seq_lines[3] |=> pins == 8'h00;
	endproperty
	a_clear: assert property (p_clear)
		else $error("latch not cleared");
	property p_write;
		wr_ok ##1 !i_seq_lines[3] |=>
			pins[$past(i_seq_lines[6:4], 2)] == $past(i_seq_lines[7], 2);
	endproperty
	a_write: assert property (p_write)
		else $error("latch write not seen on pin");
	property p_hold;
		(!(o_step && i_seq_lines[8]) && !i_seq_lines[3]) ##1
			!i_seq_lines[3] |=> $stable(pins);
	endproperty
	a_hold: assert property (p_hold)
		else $error("latch changed without write");
	property p_step;
		o_step |=> !o_step [*4] ##1 o_step;
	endproperty
	a_step: assert property (p_step)
		else $error("step spacing wrong");
endmodule // scl_props

// ---- test/scl_seq_model.sv ----
// model of the microsequencer driving select, latch and strobe lines
module scl_seq_model
(
	input wire logic i_clk, // 100 MHz clock
	input wire logic i_step, // step pulse from the block
	output logic [8:3] o_lines, // lines P3..P8
	output logic o_rdy, // ready request
	output logic [2:0] o_pulse, // tape done, disk done, command ack
	output logic o_err // no step seen in time
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_lines = 6'h00;
		o_rdy = 1'b0;
		o_pulse = 3'h0;
		o_err = 1'b0;
	end
	task sel(input logic [3:0] c);
		@(posedge i_clk);
		o_lines <= {2'b00, c};
	endtask
	task latch(input logic [2:0] a, input logic v);
		int n;
		n = 0;
		@(posedge i_clk);
		o_lines <= {1'b1, v, a, 1'b0};
		do
		begin
			@(negedge i_clk);
			n++;
		end
		while (!i_step && n < 10);
		o_err <= o_err | !i_step;
		// drop enable at once so no second step rewrites the bit
		@(posedge i_clk);
		o_lines <= 6'h00;
	endtask
	task pulse(input logic [2:0] m);
		@(posedge i_clk);
		o_pulse <= m;
		@(posedge i_clk);
		o_pulse <= 3'h0;
	endtask
	task rdy(input logic v);
		@(posedge i_clk);
		o_rdy <= v;
	endtask
endmodule // scl_seq_model

// ---- test/test_sequencer_cond_mux_and_latch.sv ----
// testbench for the condition mux, latch unit and command register
module test_sequencer_cond_mux_and_latch import scl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [1:0] i_addr = 2'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_parity_err = 1'b0;
	logic [8:0] pv = 9'h000; // ddack dreq tack xack exc busy msg cd trdy
	logic [15:0] exp_c [2] = '{16'h076A, 16'h1284};
	wire [8:3] i_seq_lines;
	wire i_ready_req, i_cmd_ack, i_scsi_done, i_tape_done, seq_err;
	wire [7:0] o_rdata, o_port_data;
	wire [5:0] o_branch_address_inputs;
	wire o_condition_input, o_step, o_ready, o_host_interrupt_line;
	wire o_xfer_req, o_scsi_pend, o_tape_pend, o_dmsg, o_scsi_attn;
	wire o_scsi_rst, o_scsi_ack, o_tape_online, o_tape_rst;
	wire [7:0] pins = {o_scsi_ack, o_tape_rst, 1'b0, o_tape_online,
		o_xfer_req, o_host_interrupt_line, o_scsi_rst, o_scsi_attn};
	int err_count = 0;
	int comparisons = 0;
	always #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
	scl_top scl_top_inst (.*, .i_ddack(pv[8]), .i_dreq(pv[7]),
		.i_tack(pv[6]), .i_xack(pv[5]), .i_exc(pv[4]), .i_busy(pv[3]),
		.i_msg(pv[2]), .i_cd(pv[1]), .i_trdy(pv[0]));
	scl_seq_model scl_seq_model_inst (.i_clk(i_clk), .i_step(o_step),
		.o_lines(i_seq_lines), .o_rdy(i_ready_req),
		.o_pulse({i_tape_done, i_scsi_done, i_cmd_ack}), .o_err(seq_err));
	// ==========================================================
	// access and check tasks
	task chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task finish_test;
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask
	task cs(input logic [3:0] c, input logic e);
		scl_seq_model_inst.sel(c);
		@(posedge i_clk);
		#1 chk(o_condition_input, e);
	endtask
	task setp(input logic [8:0] v);
		@(posedge i_clk);
		pv <= v;
		repeat (4) @(posedge i_clk);
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		#1 chk(o_ready, 8'h01);
		wr(OFS_CMD, 8'h05);
		#1 chk(o_branch_address_inputs, 8'h05);
		rd(OFS_CMD, 8'h45);
		cs(SEL_VALID, 1'b1);
		scl_seq_model_inst.pulse(3'h1);
		rd(OFS_CMD, 8'h05);
		cs(SEL_VALID, 1'b0);
		// second pattern has msg without c/d, so an or in place of and shows
		for (int p = 0; p < 2; p++)
		begin
			setp(p ? 9'h095 : 9'h16E);
			for (int c = 0; c < 16; c++)
				cs(4'(c), exp_c[p][c]);
			chk(o_dmsg, p ? 8'h00 : 8'h01);
		end
		for (int a = 0; a < 8; a++)
		begin
			scl_seq_model_inst.latch(3'(a), 1'b1);
			@(posedge i_clk);
			#1 chk(pins, 8'(1 << a) & 8'hDF);
			scl_seq_model_inst.latch(3'(a), 1'b0);
			@(posedge i_clk);
			#1 chk(pins, 8'h00);
		end
		scl_seq_model_inst.latch(3'h3, 1'b1);
		scl_seq_model_inst.latch(3'h5, 1'b1);
		scl_seq_model_inst.latch(3'h2, 1'b1);
		cs(SEL_MSG_TRDY, 1'b1);
		rd(OFS_STATUS, 8'h70);
		setp(9'h0B1);
		cs(SEL_XACK_REQ, 1'b1);
		// odd select codes also raise P3 and wipe the latch
		cs(SEL_ONE, 1'b1);
		chk(pins, 8'h00);
		// both disk request and dma acknowledge high
		setp(9'h180);
		cs(SEL_DREQ_DDACK, 1'b1);
		setp(9'h100);
		#1 chk(o_ready, 8'h00);
		scl_seq_model_inst.rdy(1'b1);
		@(posedge i_clk);
		#1 chk(o_ready, 8'h01);
		scl_seq_model_inst.rdy(1'b0);
		wr(OFS_SCSI, 8'hA5);
		#1 chk(o_port_data, 8'hA5);
		chk(o_scsi_pend, 8'h01);
		scl_seq_model_inst.pulse(3'h2);
		#1 chk(o_scsi_pend, 8'h00);
		wr(OFS_TAPE, 8'h3C);
		#1 chk(o_port_data, 8'h3C);
		chk(o_tape_pend, 8'h01);
		scl_seq_model_inst.pulse(3'h4);
		#1 chk(o_tape_pend, 8'h00);
		@(posedge i_clk);
		i_parity_err <= 1'b1;
		repeat (4) @(posedge i_clk);
		rd(OFS_CMD, 8'h85);
		@(posedge i_clk);
		i_parity_err <= 1'b0;
		repeat (2) @(posedge i_clk);
		wr(OFS_CMD, 8'h0A);
		rd(OFS_CMD, 8'h4A);
		chk(seq_err, 8'h00);
		finish_test();
	end
	initial
	begin
		repeat (20000) @(posedge i_clk);
		err_count++;
		finish_test();
	end
endmodule // test_sequencer_cond_mux_and_latch
bind scl_top scl_props scl_props_inst (.i_clk, .i_resetn, .i_seq_lines,
	.i_ready_req, .i_ddack, .i_dreq, .i_msg, .i_cd, .o_condition_input,
	.o_ready, .o_dmsg, .o_step, .o_host_interrupt_line, .o_xfer_req,
	.o_scsi_attn, .o_scsi_rst, .o_scsi_ack, .o_tape_online, .o_tape_rst);
